// ==== ilsm_pkg.sv ====
package ilsm_pkg;
	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int WIN_TIME_NS    = 10_000_000;
	localparam int WIN_CYC        = WIN_TIME_NS / CLK_PERIOD_NS;
	localparam int BLINK_TIME_NS  = 250_000_000;
	localparam int BLINK_CYC      = BLINK_TIME_NS / CLK_PERIOD_NS;

	// Inputs: coaxial, three optical, word clock
	localparam int N_IN     = 5;
	localparam int N_RX     = 4;
	localparam int IDX_COAX = 0;
	localparam int IDX_WCK  = 4;
	localparam int SEL_W    = 3;
	localparam int CNT_W    = 12;

	// Lock ranges and word clock double rate threshold, in Hz
	localparam longint COAX_LO_HZ = 28_000;
	localparam longint COAX_HI_HZ = 103_000;
	localparam longint OPT_LO_HZ  = 31_500;
	localparam longint OPT_HI_HZ  = 50_000;
	localparam longint WCK_LO_HZ  = 28_000;
	localparam longint WCK_HI_HZ  = 103_000;
	localparam longint WCK_DBL_HZ = 56_000;

	// Internal rates
	localparam longint RATE_32K_HZ  = 32_000;
	localparam longint RATE_441K_HZ = 44_100;
	localparam longint RATE_48K_HZ  = 48_000;
	localparam int     ACC_W        = 32;

	// Stream
	localparam int SAMPLE_W     = 24;
	localparam int PT_DELAY_SS  = 4;
	localparam int PT_DELAY_DBL = 8;
	localparam int PT_DEPTH     = 8;
	localparam int OPT_CH_SS    = 24;
	localparam int OPT_CH_DBL   = 12;

	typedef enum logic [1:0] {
		ST_NO_LOCK = 2'b00,
		ST_LOCK    = 2'b01,
		ST_SYNC    = 2'b10
	} ilsm_stat_t;

	typedef enum logic [1:0] {
		RS_32K  = 2'b00,
		RS_441K = 2'b01,
		RS_48K  = 2'b10
	} ilsm_rate_t;

	// Edges of a rate within a window: low bound rounds up, high down
	function automatic logic [CNT_W-1:0] win_cnt(input longint hz, input longint cyc,
		input logic up);
		longint num;
		num = hz * cyc * CLK_PERIOD_NS;
		return CNT_W'((num + (up ? 64'd999_999_999 : 64'd0)) / 64'd1_000_000_000);
	endfunction : win_cnt

	function automatic logic [ACC_W-1:0] phase_inc(input longint hz);
		return ACC_W'((hz << ACC_W) / (64'd1_000_000_000 / CLK_PERIOD_NS));
	endfunction : phase_inc
endpackage : ilsm_pkg

// ==== ilsm_meas_if.sv ====
`timescale 1ns/1ps
interface ilsm_meas_if
	#(parameter int N = ilsm_pkg::N_IN,
	  parameter int W = ilsm_pkg::CNT_W);
	logic                  ref_tick;
	logic                  win_done;
	logic [N-1:0]          edge_p;
	logic [N-1:0]          locked_rx;
	logic [N-1:0][W-1:0]   cnt;
	logic [W-1:0]          ref_cnt;

	modport meter (input ref_tick, output win_done, edge_p, locked_rx, cnt, ref_cnt);
	modport core  (output ref_tick, input win_done, edge_p, locked_rx, cnt, ref_cnt);
endinterface : ilsm_meas_if

// ==== ilsm_rate_meter.sv ====
`timescale 1ns/1ps
module ilsm_rate_meter
	#(parameter int N   = ilsm_pkg::N_IN,
	  parameter int WIN = ilsm_pkg::WIN_CYC)
	(
	// Clock and reset
	input wire logic          clk,
	input wire logic          rst_n,
	// Link pins
	input wire logic [N-1:0]  link_clk,
	input wire logic [N-1:0]  link_lock,
	// Measurements
	ilsm_meas_if.meter        m
	);
	import ilsm_pkg::*;

	localparam int TW = $clog2(WIN);

	logic [TW-1:0]    win_t;
	logic [TW-1:0]    next_win_t;
	logic [CNT_W-1:0] ref_run;
	logic [CNT_W-1:0] next_ref_run;
	logic [CNT_W-1:0] ref_fin;
	logic             win_end;

	assign win_end = (win_t == TW'(WIN - 1));

	always_comb
	begin
		next_win_t   = win_end ? '0 : win_t + 1'b1;
		ref_fin      = (m.ref_tick && ref_run != '1) ? ref_run + 1'b1 : ref_run;
		next_ref_run = win_end ? '0 : ref_fin;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			win_t      <= '0;
			ref_run    <= '0;
			m.ref_cnt  <= '0;
			m.win_done <= 1'b0;
		end
		else
		begin
			win_t      <= next_win_t;
			ref_run    <= next_ref_run;
			m.win_done <= win_end;
			if (win_end)
				m.ref_cnt <= ref_fin;
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_in
			logic             s1, s2, s3, ls1, ls2;
			logic [CNT_W-1:0] run, next_run, fin;

			// Two stages before anything looks at the pin
			assign m.edge_p[i]    = s2 & ~s3;
			assign m.locked_rx[i] = ls2;

			always_comb
			begin
				fin      = (m.edge_p[i] && run != '1) ? run + 1'b1 : run;
				next_run = win_end ? '0 : fin;
			end

			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					{s1, s2, s3, ls1, ls2} <= 5'h00;
					run                    <= '0;
					m.cnt[i]               <= '0;
				end
				else
				begin
					{s1, s2, s3} <= {link_clk[i], s1, s2};
					{ls1, ls2}   <= {link_lock[i], ls1};
					run          <= next_run;
					if (win_end)
						m.cnt[i] <= fin;
				end
			end
		end
	endgenerate
endmodule : ilsm_rate_meter

// ==== ilsm_top.sv ====
`timescale 1ns/1ps
// Behaviour
// - Each input reported as no lock, lock, sync
// - Locked but unsynchronised input indicator flashes
// - Clocks compared exactly; differing input flashes
// - All synchronous inputs show steady indicators
// - Follow mode takes sample clock from input
// - Local rates 32/44.1/48/88.2/96 kHz, 24-bit
// - Coaxial locks only within 28-103 kHz
// - Optical locks only within 31.5-50 kHz
// - Word clock accepted within 28-103 kHz
// - Double rate word clock detected, halved
// - Optical ports carry 24 channels single rate
// - Optical ports carry 12 channels double rate
// - Lock ignores channel status format, copy bits
// - Pass-through delay four samples single rate
// - Pass-through delay eight samples double rate
module ilsm_top
	import ilsm_pkg::*;
	#(parameter int WIN_CYC_P   = ilsm_pkg::WIN_CYC,
	  parameter int BLINK_CYC_P = ilsm_pkg::BLINK_CYC,
	  parameter int SAMPLE_W_P  = ilsm_pkg::SAMPLE_W)
	(
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	// Link pins: coaxial, optical x3, word clock
	input  wire logic [ilsm_pkg::N_IN-1:0]       link_clk,
	input  wire logic [ilsm_pkg::N_RX-1:0]       rx_lock,
	// Clock control
	input  wire logic                            follow_input_clock_mode,
	input  wire logic [ilsm_pkg::SEL_W-1:0]      follow_sel,
	input  wire ilsm_pkg::ilsm_rate_t            rate_sel,
	input  wire logic                            double_rate_mode,
	// Pass-through stream
	input  wire logic [SAMPLE_W_P-1:0]           pt_in_data,
	input  wire logic                            pt_in_valid,
	output logic      [SAMPLE_W_P-1:0]           pt_out_data,
	output logic                                 pt_out_valid,
	// Status
	output logic      [ilsm_pkg::N_IN-1:0][1:0]  in_status,
	output logic      [ilsm_pkg::N_IN-1:0]       led,
	output logic                                 wck_double,
	output logic                                 sample_tick,
	output logic      [4:0]                      opt_channels,
	output logic      [3:0]                      pt_delay
	);
	import ilsm_pkg::*;

	localparam logic [CNT_W-1:0] COAX_MIN = win_cnt(COAX_LO_HZ, WIN_CYC_P, 1'b1);
	localparam logic [CNT_W-1:0] COAX_MAX = win_cnt(COAX_HI_HZ, WIN_CYC_P, 1'b0);
	localparam logic [CNT_W-1:0] OPT_MIN  = win_cnt(OPT_LO_HZ, WIN_CYC_P, 1'b1);
	localparam logic [CNT_W-1:0] OPT_MAX  = win_cnt(OPT_HI_HZ, WIN_CYC_P, 1'b0);
	localparam logic [CNT_W-1:0] WCK_MIN  = win_cnt(WCK_LO_HZ, WIN_CYC_P, 1'b1);
	localparam logic [CNT_W-1:0] WCK_MAX  = win_cnt(WCK_HI_HZ, WIN_CYC_P, 1'b0);
	localparam logic [CNT_W-1:0] WCK_DBL  = win_cnt(WCK_DBL_HZ, WIN_CYC_P, 1'b1);
	localparam int               BW       = $clog2(BLINK_CYC_P);

	ilsm_meas_if #(.N(N_IN), .W(CNT_W)) meas ();

	ilsm_rate_meter #(.N(N_IN), .WIN(WIN_CYC_P)) u_meter (
		.clk       (clk),
		.rst_n     (rst_n),
		.link_clk  (link_clk),
		.link_lock ({1'b1, rx_lock}),
		.m         (meas)
	);

	function automatic logic range_ok(input int idx, input logic [CNT_W-1:0] c);
		if (idx == IDX_COAX)
			return c >= COAX_MIN && c <= COAX_MAX;
		else if (idx == IDX_WCK)
			return c >= WCK_MIN && c <= WCK_MAX;
		else
			return c >= OPT_MIN && c <= OPT_MAX;
	endfunction : range_ok

	// Word clock edges and counts, halved when running at double rate
	logic                        wck_phase, next_wck_phase, next_wck_double;
	logic [N_IN-1:0]             eff_edge;
	logic [N_IN-1:0][CNT_W-1:0]  adj_cnt;

	always_comb
	begin
		eff_edge          = meas.edge_p;
		eff_edge[IDX_WCK] = meas.edge_p[IDX_WCK] & (~wck_double | wck_phase);
		adj_cnt           = meas.cnt;
		if (wck_double)
			adj_cnt[IDX_WCK] = meas.cnt[IDX_WCK] >> 1;
		next_wck_phase  = meas.edge_p[IDX_WCK] ? ~wck_phase : wck_phase;
		next_wck_double = wck_double;
		if (meas.win_done)
			next_wck_double = meas.cnt[IDX_WCK] >= WCK_DBL;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wck_phase  <= 1'b0;
			wck_double <= 1'b0;
		end
		else
		begin
			wck_phase  <= next_wck_phase;
			wck_double <= next_wck_double;
		end
	end

	// Internal sample clock: local phase accumulator or followed input
	logic [ACC_W-1:0] acc, next_acc, inc;
	logic             carry, sel_ok, next_tick;

	always_comb
	begin
		case (rate_sel)
			RS_441K: inc = phase_inc(RATE_441K_HZ);
			RS_48K:  inc = phase_inc(RATE_48K_HZ);
			default: inc = phase_inc(RATE_32K_HZ);
		endcase
		// 32 kHz has no doubled rate; it stays at 32 kHz
		if (double_rate_mode && rate_sel != RS_32K)
			inc = inc << 1;
		{carry, next_acc} = {1'b0, acc} + {1'b0, inc};
		sel_ok = follow_sel < SEL_W'(N_IN)
			&& in_status[follow_sel] != ST_NO_LOCK;
		// Losing the followed input falls back to the local clock
		if (follow_input_clock_mode && sel_ok)
			next_tick = eff_edge[follow_sel];
		else
			next_tick = carry;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			acc         <= '0;
			sample_tick <= 1'b0;
		end
		else
		begin
			acc         <= next_acc;
			sample_tick <= next_tick;
		end
	end

	assign meas.ref_tick = sample_tick;

	// Status, judged once per measurement window
	logic [N_IN-1:0][1:0] next_status;
	logic [N_IN-1:0]      next_led;
	logic [BW-1:0]        blink_cnt, next_blink_cnt;
	logic                 blink, next_blink;

	always_comb
	begin
		next_status = in_status;
		for (int i = 0; i < N_IN; i++)
		begin
			// Lock depends only on rate and receiver, not on format bits
			if (meas.win_done)
			begin
				if (!meas.locked_rx[i] || !range_ok(i, adj_cnt[i]))
					next_status[i] = ST_NO_LOCK;
				else if (adj_cnt[i] == meas.ref_cnt)
					next_status[i] = ST_SYNC;
				else
					next_status[i] = ST_LOCK;
			end
			next_led[i] = in_status[i] == ST_SYNC
				|| (in_status[i] == ST_LOCK && blink);
		end
		next_blink_cnt = (blink_cnt == BW'(BLINK_CYC_P - 1)) ? '0 : blink_cnt + 1'b1;
		next_blink     = (blink_cnt == BW'(BLINK_CYC_P - 1)) ? ~blink : blink;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			in_status <= {N_IN{ST_NO_LOCK}};
			led       <= '0;
			blink_cnt <= '0;
			blink     <= 1'b0;
		end
		else
		begin
			in_status <= next_status;
			led       <= next_led;
			blink_cnt <= next_blink_cnt;
			blink     <= next_blink;
		end
	end

	// Pass-through delay line, advanced once per sample
	logic [PT_DEPTH-1:0][SAMPLE_W_P-1:0] line, next_line;
	logic [SAMPLE_W_P-1:0]               next_pt_data;
	logic [4:0]                          next_opt_ch;
	logic [3:0]                          next_pt_delay;

	always_comb
	begin
		next_pt_delay = double_rate_mode ? 4'(PT_DELAY_DBL) : 4'(PT_DELAY_SS);
		next_opt_ch   = double_rate_mode ? 5'(OPT_CH_DBL) : 5'(OPT_CH_SS);
		next_line     = line;
		next_pt_data  = pt_out_data;
		if (pt_in_valid)
		begin
			next_line    = {line[PT_DEPTH-2:0], pt_in_data};
			next_pt_data = line[next_pt_delay - 4'h1];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			line         <= '0;
			pt_out_data  <= '0;
			pt_out_valid <= 1'b0;
			opt_channels <= 5'(OPT_CH_SS);
			pt_delay     <= 4'(PT_DELAY_SS);
		end
		else
		begin
			line         <= next_line;
			pt_out_data  <= next_pt_data;
			pt_out_valid <= pt_in_valid;
			opt_channels <= next_opt_ch;
			pt_delay     <= next_pt_delay;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N_IN; g++)
		begin : g_chk
			a_nolock_dark: assert property (@(posedge clk) disable iff (!rst_n)
				in_status[g] == ST_NO_LOCK |=> !led[g])
				else $error("indicator lit without lock");
			a_lock_flash: assert property (@(posedge clk) disable iff (!rst_n)
				in_status[g] == ST_LOCK |=> led[g] == $past(blink))
				else $error("locked indicator not following flash");
			a_sync_steady: assert property (@(posedge clk) disable iff (!rst_n)
				in_status[g] == ST_SYNC ##1 in_status[g] == ST_SYNC |=> led[g] && $past(led[g]))
				else $error("synchronous indicator not steady");
			a_sync_exact: assert property (@(posedge clk) disable iff (!rst_n)
				meas.win_done && adj_cnt[g] != meas.ref_cnt |=> in_status[g] != ST_SYNC)
				else $error("sync declared with differing count");
		end
	endgenerate

	a_coax_range: assert property (@(posedge clk) disable iff (!rst_n)
		meas.win_done && (adj_cnt[IDX_COAX] < COAX_MIN || adj_cnt[IDX_COAX] > COAX_MAX)
		|=> in_status[IDX_COAX] == ST_NO_LOCK)
		else $error("coaxial lock outside range");
	a_opt_range: assert property (@(posedge clk) disable iff (!rst_n)
		meas.win_done && (adj_cnt[2] < OPT_MIN || adj_cnt[2] > OPT_MAX)
		|=> in_status[2] == ST_NO_LOCK)
		else $error("optical lock outside range");
	a_wck_double: assert property (@(posedge clk) disable iff (!rst_n)
		meas.win_done && meas.cnt[IDX_WCK] >= WCK_DBL |=> wck_double ##1 wck_double)
		else $error("double rate word clock not detected");
	a_follow_tick: assert property (@(posedge clk) disable iff (!rst_n)
		follow_input_clock_mode && sel_ok && !eff_edge[follow_sel] |=> !sample_tick)
		else $error("sample clock not following input");
	a_delay_single: assert property (@(posedge clk) disable iff (!rst_n)
		(pt_in_valid && !double_rate_mode)[*5] |=> pt_out_data == $past(pt_in_data, 5))
		else $error("single rate delay not four samples");
	a_delay_double: assert property (@(posedge clk) disable iff (!rst_n)
		pt_in_valid ##1 (pt_in_valid && double_rate_mode)[*8]
		|=> pt_out_data == $past(pt_in_data, 9))
		else $error("double rate delay not eight samples");
endmodule : ilsm_top

// ==== ilsm_src_model.sv ====
`timescale 1ns/1ps
module ilsm_src_model
	#(parameter int HALF_NS [5] = '{12500, 12500, 12500, 12500, 12500})
	(
	// Control
	input  wire logic       run,
	input  wire logic [3:0] lock_en,
	// Link pins
	output logic      [4:0] link_clk,
	output logic      [3:0] rx_lock
	);
	// Sources stand still low until started, then run free with fixed phase
	for (genvar i = 0; i < 5; i++)
	begin : g_src
		initial
		begin
			link_clk[i] = 1'h0;
			@(posedge run);
			forever
			begin
				link_clk[i] = 1'h1;
				#(HALF_NS[i]);
				link_clk[i] = 1'h0;
				#(HALF_NS[i]);
			end
		end
	end

	// Receiver lock only while its source runs
	assign rx_lock = lock_en & {4{run}};
endmodule : ilsm_src_model

// ==== ilsm_top_tb.sv ====
`timescale 1ns/1ps
module ilsm_top_tb;
	import ilsm_pkg::*;
	localparam int WIN = 20000;

	typedef struct {ilsm_rate_t rate; logic dbl; int ch; int dly; int lo;} ilsm_row_t;
	// Tick count over 5000 cycles lies in lo..lo+1
	ilsm_row_t rows [6] = '{'{RS_32K, 1'h0, 24, 4, 1}, '{RS_441K, 1'h0, 24, 4, 2},
		'{RS_48K, 1'h0, 24, 4, 2}, '{RS_441K, 1'h1, 12, 8, 4},
		'{RS_48K, 1'h1, 12, 8, 4}, '{RS_32K, 1'h1, 12, 8, 1}};

	logic                      clk        = 1'h0;
	logic                      rst_n      = 1'h0;
	logic                      run        = 1'h0;
	logic [3:0]                lock_en    = 4'hF;
	logic                      follow     = 1'h0;
	logic [SEL_W-1:0]          sel        = '0;
	ilsm_rate_t                rate       = RS_48K;
	logic                      dbl        = 1'h0;
	logic [SAMPLE_W-1:0]       in_data    = '0;
	logic                      in_valid   = 1'h0;
	logic [N_IN-1:0]           link_clk;
	logic [N_RX-1:0]           rx_lock;
	logic [SAMPLE_W-1:0]       out_data;
	logic                      out_valid;
	logic [N_IN-1:0][1:0]      status;
	logic [N_IN-1:0]           led;
	logic                      wck_double;
	logic                      tick;
	logic [4:0]                opt_ch;
	logic [3:0]                delay;
	logic [4:0]                all_on;
	logic [4:0]                any_on;
	int                        n_mismatch = 0;
	int                        tests_run  = 0;
	int                        cnt;
	int                        d;

	always #5 clk = ~clk;

	// Coax, opt1, wck locked to one source; opt2 too fast, opt3 off-rate
	ilsm_src_model #(.HALF_NS('{12500, 12500, 6250, 11110, 6250})) src (
		.run(run), .lock_en(lock_en), .link_clk(link_clk), .rx_lock(rx_lock));

	ilsm_top #(.WIN_CYC_P(WIN), .BLINK_CYC_P(16)) uut (
		.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .rx_lock(rx_lock),
		.follow_input_clock_mode(follow), .follow_sel(sel), .rate_sel(rate),
		.double_rate_mode(dbl), .pt_in_data(in_data), .pt_in_valid(in_valid),
		.pt_out_data(out_data), .pt_out_valid(out_valid), .in_status(status),
		.led(led), .wck_double(wck_double), .sample_tick(tick),
		.opt_channels(opt_ch), .pt_delay(delay));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi)
		begin
			n_mismatch++;
			$display("MISMATCH at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_rng

	task automatic count_ticks(input int n);
		cnt = 0;
		repeat (n)
		begin
			@(negedge clk);
			if (tick === 1'h1)
				cnt++;
		end
	endtask : count_ticks

	task automatic end_sim;
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end

	initial
	begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk(32'(status), 32'h0);
		chk(32'({wck_double, led, tick, out_valid}), 32'h0);
		chk(32'({opt_ch, delay}), 32'h184);
		@(posedge clk);
		rst_n <= 1'h1;
		repeat (600) @(posedge clk);
		run <= 1'h1;
		foreach (rows[i])
		begin
			@(posedge clk);
			rate <= rows[i].rate;
			dbl <= rows[i].dbl;
			repeat (3) @(posedge clk);
			count_ticks(5000);
			chk(32'(opt_ch), rows[i].ch);
			chk(32'(delay), rows[i].dly);
			chk_rng(cnt, rows[i].lo, rows[i].lo + 1);
		end
		@(posedge clk);
		dbl <= 1'h0;
		// Back to back samples; the tap switches in mid-stream
		for (int k = 1; k <= 25; k++)
		begin
			@(posedge clk);
			in_valid <= (k <= 24);
			in_data <= SAMPLE_W'(k);
			if (k == 13)
				dbl <= 1'h1;
			@(negedge clk);
			if (k > 1)
			begin
				d = (k - 1 > 12) ? 8 : 4;
				chk(32'(out_valid), 32'h1);
				chk(32'(out_data), (k - 1 > d) ? k - 1 - d : 0);
			end
		end
		@(negedge clk);
		chk(32'(out_valid), 32'h0);
		@(posedge clk);
		dbl <= 1'h0;
		follow <= 1'h1;
		repeat (25000) @(posedge clk);
		count_ticks(WIN);
		chk_rng(cnt, 8, 8);
		chk(32'(status), 32'({ST_SYNC, ST_LOCK, ST_NO_LOCK, ST_SYNC, ST_SYNC}));
		chk(32'(wck_double), 32'h1);
		all_on = '1;
		any_on = '0;
		repeat (40)
		begin
			@(negedge clk);
			all_on &= led;
			any_on |= led;
		end
		chk(32'({all_on, any_on}), 32'h27B);
		@(posedge clk);
		lock_en <= 4'hD;
		repeat (WIN + 100) @(posedge clk);
		@(negedge clk);
		chk(32'({status[1], led[1]}), 32'h0);
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(32'({status, wck_double, led}), 32'h0);
		chk(32'({opt_ch, delay}), 32'h184);
		end_sim();
	end
endmodule : ilsm_top_tb
